// *** hdl/ldc_pkg.sv ***
// constants for the led diagnostic and dimming configuration bank
package ldc_pkg;

    // ------------------------------------------------------------
    // register offsets (byte addresses on the plain port)
    // ------------------------------------------------------------
    localparam logic [7:0] LDC_DIAGNOSTIC_TIMING_TIMING_OFS  = 8'h7b;
    localparam logic [7:0] LDC_DEV_MASK_OFS     = 8'h7c;
    localparam logic [7:0] LDC_OUT_MASK_OFS     = 8'h7d;
    localparam logic [7:0] LDC_DIM_CFG_OFS      = 8'h7e;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int LDC_RETRY_LSB        = 4;
    localparam int LDC_BLANK_LSB        = 0;
    localparam int LDC_SUPPLY_LOW_BIT   = 7;
    localparam int LDC_UNDERVOLT_BIT    = 6;
    localparam int LDC_REF_PIN_BIT      = 5;
    localparam int LDC_THERM_WARN_BIT   = 4;
    localparam int LDC_THERM_SHUT_BIT   = 3;
    localparam int LDC_NVM_CRC_BIT      = 2;
    localparam int LDC_OUT_OPEN_BIT     = 2;
    localparam int LDC_OUT_SHORT_BIT    = 1;
    localparam int LDC_SLS_BIT          = 0;
    localparam int LDC_EXP_BIT          = 7;
    localparam int LDC_STAGGER_BIT      = 6;
    localparam int LDC_FINE_BIT         = 5;
    localparam int LDC_PSAVE_BIT        = 4;
    localparam int LDC_RATE_LSB         = 0;

    // writable bit masks; zero positions are reserved
    localparam logic [7:0] LDC_DEV_MASK_WMASK   = 8'hfc;
    localparam logic [7:0] LDC_OUT_MASK_WMASK   = 8'h07;
    localparam logic [7:0] LDC_FULL_WMASK       = 8'hff;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int LDC_CLK_HZ           = 40_000_000;
    localparam int LDC_RETRY_DENOM      = 64;

    // blank interval per code, in microseconds
    function automatic int ldc_blank_us(input logic [3:0] code);
        case (code)
            4'h0:    return 100;
            4'h1:    return 20;
            4'h2:    return 30;
            4'h3:    return 50;
            4'h4:    return 80;
            4'h5:    return 150;
            4'h6:    return 200;
            4'h7:    return 300;
            4'h8:    return 500;
            4'h9:    return 800;
            4'ha:    return 1000;
            4'hb:    return 1200;
            4'hc:    return 1500;
            4'hd:    return 2000;
            4'he:    return 3000;
            default: return 4000;
        endcase
    endfunction

    // pwm dimming rate per code, in hertz
    function automatic int ldc_rate_hz(input logic [3:0] code);
        case (code)
            4'h0:    return 200;
            4'h1:    return 250;
            4'h2:    return 300;
            4'h3:    return 350;
            4'h4:    return 400;
            4'h5:    return 500;
            4'h6:    return 600;
            4'h7:    return 800;
            4'h8:    return 1000;
            4'h9:    return 1200;
            4'ha:    return 2000;
            4'hb:    return 4000;
            4'hc:    return 5900;
            4'hd:    return 7800;
            4'he:    return 9600;
            default: return 20800;
        endcase
    endfunction

endpackage

// *** hdl/ldc_config_bank.sv ***
// configuration register bank: fault masks, diagnostic timing, dimming options

// Overview of operation
// - retry code sets (4n+4)/64 retry current
// - blank code selects diagnostic blank interval
// - reset loads fields from nvm image
// - mask bit one suppresses fault report
// - device mask bit7 gates supply-low
// - device mask bit6 gates undervoltage
// - device mask bit5 gates reference pin
// - device mask bit4 gates thermal warning
// - device mask bit3 gates thermal shutdown
// - bit2 gates nvm checksum; bits1-0 zero
// - output mask bit2 gates open; 7-3 zero
// - output mask bit1 gates output short
// - output mask bit0 gates single-led short
// - dimming bit7 selects exponential curve
// - dimming bit6 enables phase stagger
// - dimming bit5 enables fine resolution diagnostics
// - dimming bit4 enables power save
// - rate code selects pwm dimming frequency
module ldc_config_bank
    import ldc_pkg::*;
#(
    parameter int DATA_W = 8
) (
    input  wire logic               clk_sys,
    input  wire logic               rst,
    // register port
    input  wire logic [7:0]         reg_addr,
    input  wire logic [DATA_W-1:0]  reg_wdata,
    input  wire logic               reg_write,
    input  wire logic               reg_read,
    output logic [DATA_W-1:0]       reg_rdata,
    // stored non-volatile image, sampled while reset is high
    input  wire logic [7:0]         nvm_diagnostic_timing_timing,
    input  wire logic [7:0]         nvm_dev_mask,
    input  wire logic [7:0]         nvm_out_mask,
    input  wire logic [7:0]         nvm_dim_cfg,
    // raw faults from the detectors
    input  wire logic               fault_supply_low,
    input  wire logic               fault_undervoltage,
    input  wire logic               fault_reference_pin,
    input  wire logic               fault_thermal_warning,
    input  wire logic               fault_thermal_shutdown,
    input  wire logic               fault_nvm_checksum,
    input  wire logic               fault_output_open,
    input  wire logic               fault_output_short,
    input  wire logic               fault_single_led_short,
    // faults allowed through to the report
    output logic                    report_supply_low,
    output logic                    report_undervoltage,
    output logic                    report_reference_pin,
    output logic                    report_thermal_warning,
    output logic                    report_thermal_shutdown,
    output logic                    report_nvm_checksum,
    output logic                    report_output_open,
    output logic                    report_output_short,
    output logic                    report_single_led_short,
    output logic                    fault_reported,
    // configuration to the analog and pwm logic
    output logic [3:0]              retry_current_code,
    output logic [6:0]              retry_current_num,
    output logic [3:0]              blank_code,
    output logic [17:0]             blank_cycles,
    output logic                    exponential_curve_on,
    output logic                    phase_stagger_on,
    output logic                    fine_resolution_on,
    output logic                    power_save_on,
    output logic [3:0]              pulse_rate_select,
    output logic [17:0]             pulse_period_cycles
);

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [7:0] diagnostic_timing_timing_reg;
    logic [7:0] dev_mask_reg;
    logic [7:0] out_mask_reg;
    logic [7:0] dim_cfg_reg;

    // merge a write into a register, keeping reserved bits at zero
    function automatic logic [7:0] ldc_merge(input logic [7:0] wdata, input logic [7:0] wmask);
        return wdata & wmask;
    endfunction

    logic wr_diagnostic_timing;
    logic wr_dev;
    logic wr_out;
    logic wr_dim;

    // address decode for writes
    assign wr_diagnostic_timing = reg_write && (reg_addr == LDC_DIAGNOSTIC_TIMING_TIMING_OFS);
    assign wr_dev  = reg_write && (reg_addr == LDC_DEV_MASK_OFS);
    assign wr_out  = reg_write && (reg_addr == LDC_OUT_MASK_OFS);
    assign wr_dim  = reg_write && (reg_addr == LDC_DIM_CFG_OFS);

    // diagnostic timing register
    // nvm image load
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            diagnostic_timing_timing_reg <= ldc_merge(nvm_diagnostic_timing_timing, LDC_FULL_WMASK);
        end else if (wr_diagnostic_timing) begin
            diagnostic_timing_timing_reg <= ldc_merge(reg_wdata[7:0], LDC_FULL_WMASK);
        end
    end

    // device fault mask register
    // reserved bits dropped
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dev_mask_reg <= ldc_merge(nvm_dev_mask, LDC_DEV_MASK_WMASK);
        end else if (wr_dev) begin
            dev_mask_reg <= ldc_merge(reg_wdata[7:0], LDC_DEV_MASK_WMASK);
        end
    end

    // output fault mask register
    // reserved upper bits
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            out_mask_reg <= ldc_merge(nvm_out_mask, LDC_OUT_MASK_WMASK);
        end else if (wr_out) begin
            out_mask_reg <= ldc_merge(reg_wdata[7:0], LDC_OUT_MASK_WMASK);
        end
    end

    // dimming configuration register
    // live from next cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dim_cfg_reg <= ldc_merge(nvm_dim_cfg, LDC_FULL_WMASK);
        end else if (wr_dim) begin
            dim_cfg_reg <= ldc_merge(reg_wdata[7:0], LDC_FULL_WMASK);
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    logic [7:0] rd_mux;

    // unmapped addresses read zero
    always_comb begin
        case (reg_addr)
            LDC_DIAGNOSTIC_TIMING_TIMING_OFS: rd_mux = diagnostic_timing_timing_reg;
            LDC_DEV_MASK_OFS:    rd_mux = dev_mask_reg;
            LDC_OUT_MASK_OFS:    rd_mux = out_mask_reg;
            LDC_DIM_CFG_OFS:     rd_mux = dim_cfg_reg;
            default:             rd_mux = 8'h00;
        endcase
    end

    // data stands only in the cycle after the read strobe
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata <= '0;
        end else if (reg_read) begin
            reg_rdata <= DATA_W'(rd_mux);
        end else begin
            reg_rdata <= '0;
        end
    end

    // ------------------------------------------------------------
    // fault report gating
    // ------------------------------------------------------------
    // registered so the report is glitch free; costs one cycle of latency
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            report_supply_low       <= 1'b0;
            report_undervoltage     <= 1'b0;
            report_reference_pin    <= 1'b0;
            report_thermal_warning  <= 1'b0;
            report_thermal_shutdown <= 1'b0;
            report_nvm_checksum     <= 1'b0;
            report_output_open      <= 1'b0;
            report_output_short     <= 1'b0;
            report_single_led_short <= 1'b0;
        end else begin
            report_supply_low       <= fault_supply_low && !dev_mask_reg[LDC_SUPPLY_LOW_BIT];
            report_undervoltage     <= fault_undervoltage && !dev_mask_reg[LDC_UNDERVOLT_BIT];
            report_reference_pin    <= fault_reference_pin && !dev_mask_reg[LDC_REF_PIN_BIT];
            report_thermal_warning  <= fault_thermal_warning && !dev_mask_reg[LDC_THERM_WARN_BIT];
            report_thermal_shutdown <= fault_thermal_shutdown && !dev_mask_reg[LDC_THERM_SHUT_BIT];
            report_nvm_checksum     <= fault_nvm_checksum && !dev_mask_reg[LDC_NVM_CRC_BIT];
            report_output_open      <= fault_output_open && !out_mask_reg[LDC_OUT_OPEN_BIT];
            report_output_short     <= fault_output_short && !out_mask_reg[LDC_OUT_SHORT_BIT];
            report_single_led_short <= fault_single_led_short && !out_mask_reg[LDC_SLS_BIT];
        end
    end

    // summary of every unmasked fault
    assign fault_reported = report_supply_low || report_undervoltage || report_reference_pin
                         || report_thermal_warning || report_thermal_shutdown || report_nvm_checksum
                         || report_output_open || report_output_short || report_single_led_short;

    // ------------------------------------------------------------
    // configuration outputs
    // ------------------------------------------------------------
    logic [3:0] retry_field;
    logic [3:0] blank_field;
    logic [3:0] rate_field;

    assign retry_field = diagnostic_timing_timing_reg[LDC_RETRY_LSB +: 4];
    assign blank_field = diagnostic_timing_timing_reg[LDC_BLANK_LSB +: 4];
    assign rate_field  = dim_cfg_reg[LDC_RATE_LSB +: 4];

    // fields straight from flip-flops
    assign retry_current_code   = retry_field;
    assign blank_code           = blank_field;
    assign exponential_curve_on = dim_cfg_reg[LDC_EXP_BIT];
    assign phase_stagger_on     = dim_cfg_reg[LDC_STAGGER_BIT];
    assign fine_resolution_on   = dim_cfg_reg[LDC_FINE_BIT];
    assign power_save_on        = dim_cfg_reg[LDC_PSAVE_BIT];
    assign pulse_rate_select    = rate_field;

    // decoded values registered; lag the field by one cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            retry_current_num   <= '0;
            blank_cycles        <= '0;
            pulse_period_cycles <= '0;
        end else begin
            retry_current_num   <= {1'b0, retry_field, 2'b00} + 7'h04;
            blank_cycles        <= 18'(ldc_blank_us(blank_field) * (LDC_CLK_HZ / 1_000_000));
            pulse_period_cycles <= 18'(LDC_CLK_HZ / ldc_rate_hz(rate_field));
        end
    end

endmodule

// *** verif/ldc_config_bank_assertions.sv ***
// port-level checker for the configuration register bank, bound to the ldc_config_bank module
module ldc_config_bank_checker
    import ldc_pkg::*;
#(
    parameter int DATA_W = 8
) (
    input wire logic              clk_sys,
    input wire logic              rst,
    input wire logic [7:0]        reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic              reg_write,
    input wire logic              reg_read,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic [7:0]        nvm_out_mask,
    input wire logic              fault_output_open,
    input wire logic              fault_output_short,
    input wire logic              fault_single_led_short,
    input wire logic              report_output_open,
    input wire logic              report_output_short,
    input wire logic              report_single_led_short,
    input wire logic [3:0]        retry_current_code,
    input wire logic [6:0]        retry_current_num,
    input wire logic              exponential_curve_on,
    input wire logic              phase_stagger_on,
    input wire logic              fine_resolution_on,
    input wire logic              power_save_on,
    input wire logic [3:0]        pulse_rate_select,
    input wire logic [17:0]       pulse_period_cycles
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] out_sh;
    logic [2:0] out_pass;

    // ----------------------------------------
    // shadow of the output mask
    // ----------------------------------------
    // kept apart from the design so a stuck mask register shows up
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            out_sh <= nvm_out_mask & LDC_OUT_MASK_WMASK;
        end else if (reg_write && reg_addr == LDC_OUT_MASK_OFS) begin
            out_sh <= reg_wdata & LDC_OUT_MASK_WMASK;
        end
    end
    assign out_pass = {fault_output_open, fault_output_short, fault_single_led_short} & ~out_sh[2:0];

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == '0)
        else $error("read data not zero outside read reply");
    retry_num_a: assert property (!$past(rst) |-> retry_current_num == {1'b0, $past(retry_current_code), 2'b00} + 7'h04)
        else $error("retry current numerator wrong");
    rate_top_a: assert property (pulse_rate_select == 4'hf |=> pulse_period_cycles == 18'd1923)
        else $error("top dimming rate period wrong");
    dim_write_a: assert property (reg_write && reg_addr == LDC_DIM_CFG_OFS |=>
        {exponential_curve_on, phase_stagger_on, fine_resolution_on, power_save_on, pulse_rate_select} == $past(reg_wdata))
        else $error("dimming fields not updated after write");
    out_read_a: assert property (reg_read && !reg_write && reg_addr == LDC_OUT_MASK_OFS |=> reg_rdata == $past(out_sh))
        else $error("output mask read back wrong");
    open_report_a: assert property (!$past(rst) |-> report_output_open == $past(out_pass[2]))
        else $error("open report gating wrong");
    short_report_a: assert property (!$past(rst) |-> report_output_short == $past(out_pass[1]))
        else $error("short report gating wrong");
    sls_report_a: assert property (!$past(rst) |-> report_single_led_short == $past(out_pass[0]))
        else $error("single led short report gating wrong");
endmodule

bind ldc_config_bank ldc_config_bank_checker #(.DATA_W(DATA_W)) i_chk (
    .clk_sys, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .nvm_out_mask,
    .fault_output_open, .fault_output_short, .fault_single_led_short, .report_output_open,
    .report_output_short, .report_single_led_short, .retry_current_code, .retry_current_num,
    .exponential_curve_on, .phase_stagger_on, .fine_resolution_on, .power_save_on,
    .pulse_rate_select, .pulse_period_cycles);

// *** verif/ldc_config_bank_tb_top.sv ***
// self-checking bench for the configuration register bank
module ldc_config_bank_tb_top
    import ldc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic        reg_write = 1'b0, reg_read = 1'b0;
    logic [7:0]  nvm_diagnostic_timing_timing = 8'h3a, nvm_dev_mask = 8'hff, nvm_out_mask = 8'hff, nvm_dim_cfg = 8'hc5;
    logic [8:0]  flt = 9'h000, m;
    wire  [8:0]  rpt;
    logic        fault_reported, exponential_curve_on, phase_stagger_on, fine_resolution_on, power_save_on;
    logic [3:0]  retry_current_code, blank_code, pulse_rate_select;
    logic [6:0]  retry_current_num;
    logic [17:0] blank_cycles, pulse_period_cycles;
    int          bad_count = 0, n_tests = 0;
    int          blk_us[16] = '{100, 20, 30, 50, 80, 150, 200, 300, 500, 800, 1000, 1200, 1500, 2000, 3000, 4000};
    int          rate[16] = '{200, 250, 300, 350, 400, 500, 600, 800, 1000, 1200, 2000, 4000, 5900, 7800, 9600, 20800};

    ldc_config_bank i_dut (
        .clk_sys, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
        .nvm_diagnostic_timing_timing, .nvm_dev_mask, .nvm_out_mask, .nvm_dim_cfg,
        .fault_supply_low(flt[8]), .fault_undervoltage(flt[7]), .fault_reference_pin(flt[6]),
        .fault_thermal_warning(flt[5]), .fault_thermal_shutdown(flt[4]), .fault_nvm_checksum(flt[3]),
        .fault_output_open(flt[2]), .fault_output_short(flt[1]), .fault_single_led_short(flt[0]),
        .report_supply_low(rpt[8]), .report_undervoltage(rpt[7]), .report_reference_pin(rpt[6]),
        .report_thermal_warning(rpt[5]), .report_thermal_shutdown(rpt[4]), .report_nvm_checksum(rpt[3]),
        .report_output_open(rpt[2]), .report_output_short(rpt[1]), .report_single_led_short(rpt[0]),
        .fault_reported, .retry_current_code, .retry_current_num, .blank_code, .blank_cycles,
        .exponential_curve_on, .phase_stagger_on, .fine_resolution_on, .power_save_on,
        .pulse_rate_select, .pulse_period_cycles);

    // 40 mhz system clock
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t ns: got %h expected %h", $time, seen, exp);
        end
    endtask

    // strobes start one edge after the call, so back-to-back calls never collide
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_write <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        @(negedge clk_sys);
        check(reg_rdata, e);
    endtask

    task automatic summarize();
        if (bad_count == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // whole run needs under two hundred cycles
    initial begin
        repeat (4000) @(posedge clk_sys);
        bad_count++;
        summarize();
    end

    // ----------------------------------------
    // stimulus
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        rd(LDC_DIAGNOSTIC_TIMING_TIMING_OFS, 8'h3a);
        rd(LDC_DEV_MASK_OFS, 8'hfc);
        rd(LDC_OUT_MASK_OFS, 8'h07);
        rd(LDC_DIM_CFG_OFS, 8'hc5);
        check(retry_current_num, 18'd16);
        check(blank_cycles, 18'd40000);
        check(pulse_period_cycles, 18'd80000);
        @(posedge clk_sys);
        flt <= 9'h1ff;
        repeat (2) @(negedge clk_sys);
        check(rpt, 9'h000);
        check(fault_reported, 1'b0);
        // unmask one fault at a time, reserved bits written as ones
        for (int i = 0; i < 9; i++) begin
            m = ~(9'h001 << i);
            wr(LDC_DEV_MASK_OFS, {m[8:3], 2'b11});
            wr(LDC_OUT_MASK_OFS, {5'h1f, m[2:0]});
            repeat (2) @(negedge clk_sys);
            check(rpt, 9'h001 << i);
            check(fault_reported, 1'b1);
        end
        // unmasked but idle fault must not report
        @(posedge clk_sys);
        flt <= 9'h000;
        repeat (2) @(negedge clk_sys);
        check(rpt, 9'h000);
        check(fault_reported, 1'b0);
        rd(LDC_DEV_MASK_OFS, 8'h7c);
        rd(LDC_OUT_MASK_OFS, 8'h07);
        // every code of the timing and dimming fields
        for (int c = 0; c < 16; c++) begin
            wr(LDC_DIAGNOSTIC_TIMING_TIMING_OFS, {c[3:0], c[3:0]});
            wr(LDC_DIM_CFG_OFS, {c[3:0], c[3:0]});
            @(negedge clk_sys);
            check({exponential_curve_on, phase_stagger_on, fine_resolution_on, power_save_on}, c[3:0]);
            check(pulse_rate_select, c[3:0]);
            check(retry_current_code, c[3:0]);
            check(blank_code, c[3:0]);
            @(negedge clk_sys);
            check(retry_current_num, c * 4 + 4);
            check(blank_cycles, blk_us[c] * 40);
            check(pulse_period_cycles, 40_000_000 / rate[c]);
        end
        wr(8'h7f, 8'h00);
        rd(8'h7f, 8'h00);
        rd(LDC_DIM_CFG_OFS, 8'hff);
        // second reset reloads the stored image
        @(posedge clk_sys);
        nvm_dim_cfg <= 8'h5a;
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        rd(LDC_DIM_CFG_OFS, 8'h5a);
        summarize();
    end
endmodule
